// ==== skt_core.sv ====
// Behaviour
// - carry clear: skip the next instruction
// - carry skip leaves carry flag untouched
// - carry set: next instruction runs normally
// - port bit by index low skips, high runs
// - index 0..7; two words, two cycles
// - register b to timer/reload high nibbles
// - accumulator to low nibbles, one cycle
`timescale 1ns/1ps
`include "skt_defines.svh"

module skt_core #(
  parameter int PORT_WIDTH  = 8,
  parameter int TIMER_WIDTH = 8
) (
  // clock and reset
  input  wire logic                   clk,
  input  wire logic                   rst_b,
  // instruction from decode
  input  wire logic                   op_valid,
  input  wire logic [9:0]             op_word,
  // cpu resources
  input  wire logic [3:0]             acc,
  input  wire logic [3:0]             reg_b,
  input  wire logic [3:0]             reg_y,
  input  wire logic                   carry_flag,
  input  wire logic [PORT_WIDTH-1:0]  port_d_latch,
  // results
  output logic                        skip_next_q,
  output logic                        op_done_q,
  output logic                        op_busy_q,
  output logic                        carry_write_q,
  output logic                        timer_load_q,
  output logic [TIMER_WIDTH-1:0]      timer_one_q,
  output logic [TIMER_WIDTH-1:0]      timer_one_reload_q
);

  // ----------------------------------------
  // state
  // ----------------------------------------
  skt_pkg::skt_regs_type  r_q;
  skt_pkg::skt_regs_type  r_d;
  skt_pkg::skt_test_type  test_sel;
  logic                   eval_skip;
  logic [3:0]             eval_index;

  // ----------------------------------------
  // skip evaluation
  // ----------------------------------------
  skt_skip_eval #(
    .PORT_WIDTH   (PORT_WIDTH)
  ) u_eval (
    .test_sel     (test_sel),
    .carry_flag   (carry_flag),
    .port_d_latch (port_d_latch),
    .index        (eval_index),
    .skip         (eval_skip)
  );

  assign eval_index = r_q.index;

  always_comb begin
    test_sel = skt_pkg::SEL_NONE;
    if (op_valid && r_q.state == skt_pkg::ST_IDLE && op_word == `SKT_OP_SKIP_ON_CARRY_CLEAR) begin
      test_sel = skt_pkg::SEL_CARRY;
    end else if (op_valid && r_q.state == skt_pkg::ST_PORT_WORD2 && op_word == `SKT_OP_SKIP_PORT_BIT_LOW_W2) begin
      test_sel = skt_pkg::SEL_PORT_BIT;
    end
  end

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb begin
    r_d            = r_q;
    r_d.skip       = 1'b0;
    r_d.done       = 1'b0;
    r_d.timer_load = 1'b0;
    case (r_q.state)
      skt_pkg::ST_IDLE: begin
        r_d.busy = 1'b0;
        if (op_valid) begin
          if (op_word == `SKT_OP_SKIP_ON_CARRY_CLEAR) begin
            r_d.skip = eval_skip;
            r_d.done = 1'b1;
          end else if (op_word == `SKT_OP_SKIP_PORT_BIT_LOW_W1) begin
            r_d.index = reg_y;
            r_d.busy  = 1'b1;
            r_d.state = skt_pkg::ST_PORT_WORD2;
          end else if (op_word == `SKT_OP_TIMER_ONE_LOAD) begin
            r_d.timer_one[`SKT_NIB_HI_MSB:`SKT_NIB_HI_LSB]        = reg_b;
            r_d.timer_one_reload[`SKT_NIB_HI_MSB:`SKT_NIB_HI_LSB] = reg_b;
            r_d.timer_one[`SKT_NIB_LO_MSB:`SKT_NIB_LO_LSB]        = acc;
            r_d.timer_one_reload[`SKT_NIB_LO_MSB:`SKT_NIB_LO_LSB] = acc;
            r_d.timer_load = 1'b1;
            r_d.done       = 1'b1;
          end
        end
      end
      skt_pkg::ST_PORT_WORD2: begin
        if (op_valid) begin
          r_d.state = skt_pkg::ST_IDLE;
          r_d.busy  = 1'b0;
          if (op_word == `SKT_OP_SKIP_PORT_BIT_LOW_W2) begin
            r_d.skip = eval_skip;
            r_d.done = 1'b1;
          end
        end
      end
      default: begin
        r_d.state = skt_pkg::ST_IDLE;
        r_d.busy  = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      r_q.state            <= skt_pkg::ST_IDLE;
      r_q.index            <= `SKT_INDEX_RESET;
      r_q.skip             <= 1'b0;
      r_q.done             <= 1'b0;
      r_q.busy             <= 1'b0;
      r_q.timer_load       <= 1'b0;
      r_q.timer_one        <= `SKT_TIMER_RESET;
      r_q.timer_one_reload <= `SKT_TIMER_RESET;
    end else begin
      r_q <= r_d;
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign skip_next_q        = r_q.skip;
  assign op_done_q          = r_q.done;
  assign op_busy_q          = r_q.busy;
  assign carry_write_q      = 1'b0;
  assign timer_load_q       = r_q.timer_load;
  assign timer_one_q        = r_q.timer_one;
  assign timer_one_reload_q = r_q.timer_one_reload;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  chk_carry_clear_skip: assert property (@(posedge clk) disable iff (!rst_b)
    (op_valid && r_q.state == skt_pkg::ST_IDLE && op_word == `SKT_OP_SKIP_ON_CARRY_CLEAR && !carry_flag)
    |=> (skip_next_q && op_done_q))
    else $error("carry clear did not skip");

  chk_carry_untouched: assert property (@(posedge clk) disable iff (!rst_b)
    (op_valid && op_word == `SKT_OP_SKIP_ON_CARRY_CLEAR) |=> !carry_write_q [*2])
    else $error("carry skip wrote carry");

  chk_carry_set_run: assert property (@(posedge clk) disable iff (!rst_b)
    (op_valid && r_q.state == skt_pkg::ST_IDLE && op_word == `SKT_OP_SKIP_ON_CARRY_CLEAR && carry_flag)
    |=> (!skip_next_q && op_done_q))
    else $error("carry set skipped");

  chk_port_bit_test: assert property (@(posedge clk) disable iff (!rst_b)
    (op_valid && r_q.state == skt_pkg::ST_PORT_WORD2 && op_word == `SKT_OP_SKIP_PORT_BIT_LOW_W2
     && r_q.index <= `SKT_PORT_BIT_MAX)
    |=> (skip_next_q == !$past(port_d_latch[r_q.index[2:0]])))
    else $error("port bit skip mismatch");

  chk_port_two_words: assert property (@(posedge clk) disable iff (!rst_b)
    (op_valid && r_q.state == skt_pkg::ST_IDLE && op_word == `SKT_OP_SKIP_PORT_BIT_LOW_W1)
    |=> (op_busy_q && !op_done_q && r_q.index == $past(reg_y)))
    else $error("port skip first word not held");

  chk_timer_high: assert property (@(posedge clk) disable iff (!rst_b)
    (op_valid && r_q.state == skt_pkg::ST_IDLE && op_word == `SKT_OP_TIMER_ONE_LOAD)
    |=> (timer_one_q[7:4] == $past(reg_b) && timer_one_reload_q[7:4] == $past(reg_b)))
    else $error("timer high nibble wrong");

  chk_timer_low: assert property (@(posedge clk) disable iff (!rst_b)
    (op_valid && r_q.state == skt_pkg::ST_IDLE && op_word == `SKT_OP_TIMER_ONE_LOAD)
    |=> (timer_one_q[3:0] == $past(acc) && timer_one_reload_q[3:0] == $past(acc)
         && op_done_q && timer_load_q))
    else $error("timer low nibble wrong");

  chk_carry_no_wait: assert property (@(posedge clk) disable iff (!rst_b)
    (op_valid && r_q.state == skt_pkg::ST_IDLE && op_word == `SKT_OP_SKIP_ON_CARRY_CLEAR)
    |=> (!op_busy_q && op_done_q))
    else $error("carry skip did not finish in one cycle");

  chk_skip_with_done: assert property (@(posedge clk) disable iff (!rst_b)
    skip_next_q
    |-> op_done_q)
    else $error("skip without done");

  chk_port_word2_done: assert property (@(posedge clk) disable iff (!rst_b)
    (op_valid && r_q.state == skt_pkg::ST_PORT_WORD2 && op_word == `SKT_OP_SKIP_PORT_BIT_LOW_W2)
    |=> (op_done_q && !op_busy_q))
    else $error("port skip second word not done");

  chk_port_index_high: assert property (@(posedge clk) disable iff (!rst_b)
    (op_valid && r_q.state == skt_pkg::ST_PORT_WORD2 && r_q.index > `SKT_PORT_BIT_MAX)
    |=> !skip_next_q)
    else $error("index above range skipped");

  chk_port_abort_quiet: assert property (@(posedge clk) disable iff (!rst_b)
    (op_valid && r_q.state == skt_pkg::ST_PORT_WORD2 && op_word != `SKT_OP_SKIP_PORT_BIT_LOW_W2)
    |=> (!op_done_q && !skip_next_q && !op_busy_q))
    else $error("aborted port skip finished");

  chk_busy_state: assert property (@(posedge clk) disable iff (!rst_b)
    op_busy_q
    |-> (r_q.state == skt_pkg::ST_PORT_WORD2))
    else $error("busy outside second word wait");

  chk_load_with_done: assert property (@(posedge clk) disable iff (!rst_b)
    timer_load_q
    |-> op_done_q)
    else $error("load without done");

  chk_timer_hold: assert property (@(posedge clk) disable iff (!rst_b)
    (rst_b && !(op_valid && r_q.state == skt_pkg::ST_IDLE && op_word == `SKT_OP_TIMER_ONE_LOAD))
    |=> ($stable(timer_one_q) && $stable(timer_one_reload_q)))
    else $error("timer changed without load");

endmodule

// ==== skt_defines.svh ====
`ifndef SKT_DEFINES_SVH
`define SKT_DEFINES_SVH

// ----------------------------------------
// instruction words
// ----------------------------------------
`define SKT_OP_SKIP_ON_CARRY_CLEAR   10'h02f
`define SKT_OP_SKIP_PORT_BIT_LOW_W1  10'h024
`define SKT_OP_SKIP_PORT_BIT_LOW_W2  10'h02b
`define SKT_OP_TIMER_ONE_LOAD        10'h230

// ----------------------------------------
// field positions and limits
// ----------------------------------------
`define SKT_NIB_HI_MSB               7
`define SKT_NIB_HI_LSB               4
`define SKT_NIB_LO_MSB               3
`define SKT_NIB_LO_LSB               0
`define SKT_PORT_BIT_MAX             4'h7

// ----------------------------------------
// reset values
// ----------------------------------------
`define SKT_TIMER_RESET              8'hff
`define SKT_INDEX_RESET              4'h0

`endif

// ==== skt_pkg.sv ====
package skt_pkg;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_PORT_WORD2
  } skt_state_type;

  typedef enum logic [1:0] {
    SEL_NONE,
    SEL_CARRY,
    SEL_PORT_BIT
  } skt_test_type;

  typedef struct packed {
    skt_state_type state;
    logic [3:0]    index;
    logic          skip;
    logic          done;
    logic          busy;
    logic          timer_load;
    logic [7:0]    timer_one;
    logic [7:0]    timer_one_reload;
  } skt_regs_type;

endpackage

// ==== skt_skip_eval.sv ====
`timescale 1ns/1ps
`include "skt_defines.svh"

module skt_skip_eval #(
  parameter int PORT_WIDTH = 8
) (
  // test selection
  input  wire skt_pkg::skt_test_type     test_sel,
  // tested sources
  input  wire logic                      carry_flag,
  input  wire logic [PORT_WIDTH-1:0]     port_d_latch,
  input  wire logic [3:0]                index,
  // result
  output logic                           skip
);

  // ----------------------------------------
  // bit pick with out-of-range guard
  // ----------------------------------------
  function automatic logic port_bit_low(input logic [PORT_WIDTH-1:0] port, input logic [3:0] idx);
    logic res;
    res = 1'b0;
    if (idx <= `SKT_PORT_BIT_MAX) begin
      res = ~port[idx[2:0]];
    end
    return res;
  endfunction

  always_comb begin
    case (test_sel)
      skt_pkg::SEL_CARRY:    skip = ~carry_flag;
      skt_pkg::SEL_PORT_BIT: skip = port_bit_low(port_d_latch, index);
      default:               skip = 1'b0;
    endcase
  end

endmodule

// ==== skt_core_tb.sv ====
`timescale 1ns/1ps
`include "skt_defines.svh"

module skt_core_tb;
  // ----------------------------------------
  // signals
  // ----------------------------------------
  logic       clk          = 1'b0;
  logic       rst_b        = 1'b0;
  logic       op_valid     = 1'b0;
  logic [9:0] op_word      = 10'h000;
  logic [3:0] acc          = 4'h0;
  logic [3:0] reg_b        = 4'h0;
  logic [3:0] reg_y        = 4'h0;
  logic       carry_flag   = 1'b0;
  logic [7:0] port_d_latch = 8'h00;
  logic       skip_next_q;
  logic       op_done_q;
  logic       op_busy_q;
  logic       carry_write_q;
  logic       timer_load_q;
  logic [7:0] timer_one_q;
  logic [7:0] timer_one_reload_q;
  int         n_errors     = 0;
  int         total_checks = 0;

  always #50 clk = ~clk;

  skt_core i_dut (
    .clk                (clk),
    .rst_b              (rst_b),
    .op_valid           (op_valid),
    .op_word            (op_word),
    .acc                (acc),
    .reg_b              (reg_b),
    .reg_y              (reg_y),
    .carry_flag         (carry_flag),
    .port_d_latch       (port_d_latch),
    .skip_next_q        (skip_next_q),
    .op_done_q          (op_done_q),
    .op_busy_q          (op_busy_q),
    .carry_write_q      (carry_write_q),
    .timer_load_q       (timer_load_q),
    .timer_one_q        (timer_one_q),
    .timer_one_reload_q (timer_one_reload_q)
  );

  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
    total_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic issue(input logic [9:0] w, input logic [3:0] a, input logic [3:0] b,
                       input logic [3:0] y, input logic c, input logic [7:0] p);
    @(posedge clk);
    op_valid     <= 1'b1;
    op_word      <= w;
    acc          <= a;
    reg_b        <= b;
    reg_y        <= y;
    carry_flag   <= c;
    port_d_latch <= p;
    @(posedge clk);
    op_valid <= 1'b0;
    #1;
  endtask

  task automatic conclude();
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic test_carry();
    for (int c = 0; c < 2; c++) begin
      issue(`SKT_OP_SKIP_ON_CARRY_CLEAR, 4'h0, 4'h0, 4'h0, c[0], 8'h00);
      check("carry done", 8'h01, {7'h00, op_done_q});
      check("carry skip", {7'h00, ~c[0]}, {7'h00, skip_next_q});
      check("carry write", 8'h00, {7'h00, carry_write_q});
      @(posedge clk);
      #1;
      check("carry pulse end", 8'h00, {6'h00, op_done_q, skip_next_q});
      check("carry write idle", 8'h00, {7'h00, carry_write_q});
    end
  endtask

  task automatic test_port();
    logic [7:0] p;
    for (int y = 0; y < 9; y++) begin
      for (int b = 0; b < 2; b++) begin
        p = (y < 8) ? (8'h01 << y) : 8'h00;
        if (b == 0) p = ~p;
        issue(`SKT_OP_SKIP_PORT_BIT_LOW_W1, 4'h0, 4'h0, y[3:0], 1'b0, ~p);
        check("port busy", 8'h01, {6'h00, op_done_q, op_busy_q});
        issue(`SKT_OP_SKIP_PORT_BIT_LOW_W2, 4'h0, 4'h0, 4'h0, 1'b0, p);
        check("port done busy", 8'h02, {6'h00, op_done_q, op_busy_q});
        check("port skip", {7'h00, (y < 8) && (b == 0)}, {7'h00, skip_next_q});
      end
    end
    issue(`SKT_OP_SKIP_PORT_BIT_LOW_W1, 4'h0, 4'h0, 4'h2, 1'b0, 8'h00);
    issue(`SKT_OP_SKIP_ON_CARRY_CLEAR, 4'h0, 4'h0, 4'h0, 1'b0, 8'h00);
    check("abort", 8'h00, {5'h00, op_done_q, op_busy_q, skip_next_q});
    issue(10'h000, 4'h0, 4'h0, 4'h0, 1'b0, 8'h00);
    check("ignored word", 8'h00, {5'h00, op_done_q, op_busy_q, skip_next_q});
  endtask

  task automatic test_timer();
    logic [7:0] v;
    v = 8'h00;
    for (int i = 0; i < 3; i++) begin
      v = (i == 0) ? 8'ha5 : ((i == 1) ? 8'h0f : 8'hf0);
      issue(`SKT_OP_TIMER_ONE_LOAD, v[3:0], v[7:4], 4'h0, 1'b0, 8'h00);
      check("timer", v, timer_one_q);
      check("reload", v, timer_one_reload_q);
      check("load done", 8'h03, {6'h00, timer_load_q, op_done_q});
    end
    @(posedge clk);
    #1;
    check("timer hold", 8'hf0, timer_one_q);
    check("load end", 8'h00, {6'h00, timer_load_q, op_done_q});
  endtask

  task automatic test_reset();
    issue(`SKT_OP_SKIP_PORT_BIT_LOW_W1, 4'h0, 4'h0, 4'h1, 1'b0, 8'h00);
    rst_b <= 1'b0;
    @(posedge clk);
    rst_b <= 1'b1;
    #1;
    check("mid reset busy", 8'h00, {6'h00, op_done_q, op_busy_q});
    check("mid reset timer", 8'hff, timer_one_q);
    check("mid reset reload", 8'hff, timer_one_reload_q);
    issue(`SKT_OP_SKIP_PORT_BIT_LOW_W2, 4'h0, 4'h0, 4'h0, 1'b0, 8'h00);
    check("second word alone", 8'h00, {5'h00, op_done_q, op_busy_q, skip_next_q});
  endtask

  // ----------------------------------------
  // main sequence and watchdog
  // ----------------------------------------
  initial begin
    repeat (5) @(posedge clk);
    rst_b <= 1'b1;
    #1;
    check("reset timer", 8'hff, timer_one_q);
    check("reset reload", 8'hff, timer_one_reload_q);
    check("reset flags", 8'h00, {4'h0, skip_next_q, op_done_q, op_busy_q, timer_load_q});
    test_carry();
    test_port();
    test_timer();
    test_reset();
    conclude();
  end

  initial begin
    #1000000;
    n_errors++;
    conclude();
  end

endmodule
